/* rtl/nvde_pkg.sv */
package nvde_pkg;

  // ----------------------------------------------------------------
  // Clock rate and cycle timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ       = 100;   // ref_clk rate in MHz
  localparam int WIPE_SHORT_US = 3200;  // Erase time 3.2 ms
  localparam int STORE_SHORT_US = 2200; // Write time 2.2 ms
  localparam int WIPE_LONG_US  = 3700;  // Erase time 3.7 ms
  localparam int STORE_LONG_US = 3000;  // Write time 3.0 ms
  localparam int CNT_W         = 19;    // Cycle counter width

  // ----------------------------------------------------------------
  // Memory geometry
  // ----------------------------------------------------------------
  localparam int MEM_BYTES = 2048;      // Data store size
  localparam int ADDR_W    = 11;        // Byte address width
  localparam int HIGH_W    = 3;         // High address register width
  localparam int PAGE_LEN  = 16;        // Page buffer bytes

  // ----------------------------------------------------------------
  // Register select codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_ADDR_LOW  = 2'h0; // nv_addr_low
  localparam logic [1:0] SEL_ADDR_HIGH = 2'h1; // nv_addr_high
  localparam logic [1:0] SEL_DATA      = 2'h2; // nv_data_byte
  localparam logic [1:0] SEL_CONTROL   = 2'h3; // nv_control
  localparam logic [7:0] DATA_RESET    = 8'h00; // nv_data_byte reset
  localparam logic [7:0] CTRL_RESET    = 8'h00; // nv_control reset

  // Control register layout, bit 7 first
  typedef struct packed {
    logic cycleTimeSelect; // Bit 7: long cycle times
    logic wipeAllow;       // Bit 6: erase enable
    logic wipeGo;          // Bit 5: erase start / busy
    logic pageMode;        // Bit 4: page operation mode
    logic storeAllow;      // Bit 3: write enable
    logic storeGo;         // Bit 2: write start / busy
    logic fetchAllow;      // Bit 1: read enable
    logic fetchGo;         // Bit 0: read start / busy
  } nvde_ctrl_t;

  // Register access request from the CPU
  typedef struct packed {
    logic       write;     // One-cycle write strobe
    logic [1:0] sel;       // Register select
    logic [7:0] data;      // Write data
  } nvde_sfr_req_t;

  // Timed cycle states
  typedef enum logic [1:0] {
    CYC_IDLE,
    CYC_WIPE,
    CYC_STORE
  } nvde_cyc_t;

endpackage : nvde_pkg

/* rtl/nvde_control.sv */
`timescale 1ns/100ps
// Behaviour
// [R1] Data byte register, read/write, resets zero
// [R2] Short timing: erase 3.2 ms, write 2.2 ms
// [R3] Long timing: erase 3.7 ms, write 3.0 ms
// [R4] Erase refused while erase enable low
// [R5] Erase end clears erase enable
// [R6] Erase start bit busy until erase ends
// [R7] Erase start ignored without prior enable
// [R8] Mode bit selects byte or page operation
// [R9] Sixteen byte internal page buffer
// [R10] Write blocked while write enable low
// [R11] Write end clears write enable
// [R12] Write start bit busy until write ends
// [R13] Write start ignored without prior enable
// [R14] 2048 bytes, 11-bit address from two registers
// [R15] Read starts only if enabled, self-clears
// [R16] Firmware sets one enable/start per write
// [R17] Completion pulse when erase or write ends
// [R18] Completion taken in system clock domain
module nvde_control #(
  parameter logic [18:0] WIPE_SHORT_CYC  =
    19'(nvde_pkg::WIPE_SHORT_US * nvde_pkg::CLK_MHZ),  // Erase, short
  parameter logic [18:0] STORE_SHORT_CYC =
    19'(nvde_pkg::STORE_SHORT_US * nvde_pkg::CLK_MHZ), // Write, short
  parameter logic [18:0] WIPE_LONG_CYC   =
    19'(nvde_pkg::WIPE_LONG_US * nvde_pkg::CLK_MHZ),   // Erase, long
  parameter logic [18:0] STORE_LONG_CYC  =
    19'(nvde_pkg::STORE_LONG_US * nvde_pkg::CLK_MHZ)   // Write, long
) (
  input  wire logic                  ref_clk,   // System clock
  input  wire logic                  rst_n,     // Sync reset, low
  input  wire nvde_pkg::nvde_sfr_req_t sfrReq,  // Register write request
  input  wire logic [1:0]            sfrRdSel,  // Register read select
  output logic [7:0]                 sfrRdData, // Register read data
  output logic                       cycleDone  // Erase/write end pulse
);
  import nvde_pkg::*;

  // All checks below run on ref_clk and rest while reset is held
  default clocking chkClk @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    nvde_ctrl_t                     ctl;      // Control register
    logic [7:0]                     data;     // Data byte register
    logic [7:0]                     addrLow;  // Low address register
    logic [HIGH_W-1:0]              addrHigh; // High address register
    nvde_cyc_t                      cyc;      // Timed cycle state
    logic [CNT_W-1:0]               count;    // Remaining cycles
    logic [PAGE_LEN-1:0][7:0]       pageBuf;  // Page buffer bytes
    logic [PAGE_LEN-1:0]            tags;     // Page bytes tagged
    logic                           doneEv;   // Completion pulse
  } nvde_state_t;

  nvde_state_t      st_q;                 // Registered state
  nvde_state_t      st_d;                 // Next state
  logic [7:0]       mem [MEM_BYTES];      // Nonvolatile array
  logic [ADDR_W-1:0] addr;                // Current byte address
  logic             finish;               // Timed cycle ends now
  nvde_ctrl_t       wCtl;                 // Control write view

  // Saturating increment of the in-page nibble
  function automatic logic [7:0] nib_inc(input logic [7:0] a);
    nib_inc = (a[3:0] == 4'hf) ? a : a + 8'h01;
  endfunction : nib_inc

  // Cycle length for an operation and timing choice
  function automatic logic [CNT_W-1:0] cyc_len(input logic isWipe,
                                               input logic longSel);
    if (isWipe) begin
      cyc_len = longSel ? WIPE_LONG_CYC : WIPE_SHORT_CYC;
    end else begin
      cyc_len = longSel ? STORE_LONG_CYC : STORE_SHORT_CYC;
    end
  endfunction : cyc_len

  assign addr      = {st_q.addrHigh, st_q.addrLow}; // [R14]
  assign wCtl      = nvde_ctrl_t'(sfrReq.data);
  assign finish    = (st_q.cyc != CYC_IDLE) && (st_q.count == '0);
  assign cycleDone = st_q.doneEv;                    // [R17]

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  // Unused high address bits read as zero
  always_comb begin
    unique case (sfrRdSel)
      SEL_ADDR_LOW:  sfrRdData = st_q.addrLow;
      SEL_ADDR_HIGH: sfrRdData = {5'h00, st_q.addrHigh};
      SEL_DATA:      sfrRdData = st_q.data;
      SEL_CONTROL:   sfrRdData = st_q.ctl;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d        = st_q;
    st_d.doneEv = 1'b0;
    // Firmware register writes
    if (sfrReq.write) begin
      unique case (sfrReq.sel)
        SEL_ADDR_LOW:  st_d.addrLow  = sfrReq.data;
        SEL_ADDR_HIGH: st_d.addrHigh = sfrReq.data[HIGH_W-1:0];
        SEL_DATA: begin
          st_d.data = sfrReq.data;                   // [R1]
          // Page mode tags the byte and steps the address
          if (st_q.ctl.pageMode) begin               // [R8] [R9]
            st_d.pageBuf[st_q.addrLow[3:0]] = sfrReq.data;
            st_d.tags[st_q.addrLow[3:0]]    = 1'b1;
            st_d.addrLow = nib_inc(st_q.addrLow);
          end
        end
        SEL_CONTROL: begin
          st_d.ctl.cycleTimeSelect = wCtl.cycleTimeSelect;
          st_d.ctl.pageMode        = wCtl.pageMode;
          st_d.ctl.wipeAllow       = wCtl.wipeAllow;
          st_d.ctl.storeAllow      = wCtl.storeAllow;
          st_d.ctl.fetchAllow      = wCtl.fetchAllow;
          // Start bits only take with the enable already high
          if (wCtl.wipeGo && st_q.ctl.wipeAllow &&
              st_q.cyc == CYC_IDLE) begin            // [R4] [R7]
            st_d.ctl.wipeGo = 1'b1;
            st_d.cyc        = CYC_WIPE;
            st_d.count      = cyc_len(1'b1, wCtl.cycleTimeSelect) -
                              19'h00001;             // [R2] [R3]
          end else if (wCtl.storeGo && st_q.ctl.storeAllow &&
                       st_q.cyc == CYC_IDLE) begin   // [R10] [R13]
            st_d.ctl.storeGo = 1'b1;
            st_d.cyc         = CYC_STORE;
            st_d.count       = cyc_len(1'b0, wCtl.cycleTimeSelect) -
                               19'h00001;            // [R2] [R3]
          end else if (wCtl.fetchGo && st_q.ctl.fetchAllow &&
                       st_q.cyc == CYC_IDLE) begin   // [R15]
            st_d.ctl.fetchGo = 1'b1;
          end
        end
      endcase
    end
    // Read takes one cycle, then the start bit drops
    if (st_q.ctl.fetchGo) begin                      // [R15]
      st_d.data        = mem[addr];
      st_d.ctl.fetchGo = 1'b0;
      if (st_q.ctl.pageMode) begin
        st_d.addrLow = nib_inc(st_q.addrLow);
      end
    end
    // Timed erase and write cycles
    if (finish) begin                                // [R18]
      st_d.doneEv = 1'b1;                            // [R17]
      st_d.cyc    = CYC_IDLE;
      st_d.tags   = '0;
      if (st_q.cyc == CYC_WIPE) begin
        st_d.ctl.wipeGo    = 1'b0;                   // [R6]
        st_d.ctl.wipeAllow = 1'b0;                   // [R5]
      end else begin
        st_d.ctl.storeGo    = 1'b0;                  // [R12]
        st_d.ctl.storeAllow = 1'b0;                  // [R11]
      end
    end else if (st_q.cyc != CYC_IDLE) begin
      st_d.count = st_q.count - 19'h00001;
    end
    // Dropping the erase enable empties the page buffer
    if (st_q.ctl.wipeAllow && !st_d.ctl.wipeAllow) begin // [R9]
      st_d.pageBuf = '0;
      st_d.tags    = '0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q <= '{ctl: nvde_ctrl_t'(CTRL_RESET), data: DATA_RESET,
                cyc: CYC_IDLE, default: '0};         // [R1]
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Array update at cycle end
  // ----------------------------------------------------------------
  // Array keeps its contents across reset
  always_ff @(posedge ref_clk) begin
    if (rst_n && finish) begin
      if (!st_q.ctl.pageMode) begin                  // [R8]
        mem[addr] <= (st_q.cyc == CYC_WIPE) ? 8'h00 : st_q.data;
      end else begin
        for (int i = 0; i < PAGE_LEN; i++) begin
          if (st_q.tags[i]) begin
            mem[{addr[ADDR_W-1:4], 4'(i)}] <=
              (st_q.cyc == CYC_WIPE) ? 8'h00 : st_q.pageBuf[i];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] busyLen_q;   // Cycles with a start bit high
  logic [CNT_W-1:0] expLen_q;    // Expected cycle length
  logic             busyGo;      // Erase or write start bit high
  assign busyGo = st_q.ctl.wipeGo | st_q.ctl.storeGo;

  always_ff @(posedge ref_clk) begin
    if (!rst_n || !busyGo) begin
      busyLen_q <= '0;
    end else begin
      busyLen_q <= busyLen_q + 19'h00001;
    end
    if (st_d.cyc != CYC_IDLE && st_q.cyc == CYC_IDLE) begin
      expLen_q <= cyc_len(st_d.cyc == CYC_WIPE,
                          st_d.ctl.cycleTimeSelect);
    end
  end

  sequence wipeEnds;
    !st_q.ctl.wipeGo && !st_q.ctl.wipeAllow && cycleDone;
  endsequence

  sequence storeEnds;
    !st_q.ctl.storeGo && !st_q.ctl.storeAllow && cycleDone;
  endsequence

  // Erase start needs the enable from the cycle before
  wipe_guard_a: assert property ( // [R4] [R7]
    $rose(st_q.ctl.wipeGo) |-> $past(st_q.ctl.wipeAllow))
    else $error("erase started without enable");

  // Write start needs the enable from the cycle before
  store_guard_a: assert property ( // [R10] [R13]
    $rose(st_q.ctl.storeGo) |-> $past(st_q.ctl.storeAllow))
    else $error("write started without enable");

  // Erase start bit stays high through the erase
  wipe_busy_a: assert property ( // [R6]
    (st_q.cyc == CYC_WIPE) |-> st_q.ctl.wipeGo)
    else $error("erase start bit low while busy");

  // Write start bit stays high through the write
  store_busy_a: assert property ( // [R12]
    (st_q.cyc == CYC_STORE) |-> st_q.ctl.storeGo)
    else $error("write start bit low while busy");

  // Erase end drops start and enable and pulses done
  wipe_end_a: assert property ( // [R5] [R17]
    (finish && st_q.cyc == CYC_WIPE) |=> wipeEnds)
    else $error("erase end did not clear bits");

  // Write end drops start and enable and pulses done
  store_end_a: assert property ( // [R11] [R17]
    (finish && st_q.cyc == CYC_STORE) |=> storeEnds)
    else $error("write end did not clear bits");

  // Busy time matches the selected cycle length
  cycle_time_a: assert property ( // [R2] [R3]
    $fell(busyGo) |-> ($past(busyLen_q) + 19'h00001 == expLen_q))
    else $error("erase or write cycle length wrong");

  // Read finishes in one cycle with the array byte
  fetch_clear_a: assert property ( // [R15]
    $rose(st_q.ctl.fetchGo) |=> !st_q.ctl.fetchGo ##0
      (st_q.data == $past(mem[addr])))
    else $error("read did not complete in one cycle");

  // Page address stops at the end of the page
  page_stop_a: assert property ( // [R9]
    (st_q.ctl.pageMode && st_q.addrLow[3:0] == 4'hf && st_q.cyc == CYC_IDLE)
      |=> (st_q.addrLow[3:0] == 4'hf) || $past(sfrReq.write))
    else $error("page address rolled over");

  // Control register writes, for the refusal checks
  logic ctlWrite;                // Strobe aimed at the control register
  assign ctlWrite = sfrReq.write && (sfrReq.sel == SEL_CONTROL);

  // Erase start written without a prior enable starts nothing
  wipe_refuse_a: assert property ( // [R4] [R7]
    (ctlWrite && wCtl.wipeGo && !st_q.ctl.wipeAllow) |=>
      !$rose(st_q.ctl.wipeGo))
    else $error("erase started while refused");

  // Write start written without a prior enable starts nothing
  store_refuse_a: assert property ( // [R10] [R13]
    (ctlWrite && wCtl.storeGo && !st_q.ctl.storeAllow) |=>
      !$rose(st_q.ctl.storeGo))
    else $error("write started while refused");

  // Read start written without a prior enable starts nothing
  fetch_refuse_a: assert property ( // [R15]
    (ctlWrite && wCtl.fetchGo && !st_q.ctl.fetchAllow) |=>
      !$rose(st_q.ctl.fetchGo))
    else $error("read started while refused");

  // Completion pulse lasts a single cycle
  done_pulse_a: assert property ( // [R17]
    cycleDone |=> !cycleDone)
    else $error("completion pulse too long");

  // Completion pulse comes exactly when a busy start bit falls
  done_match_a: assert property ( // [R17] [R18]
    cycleDone == $fell(busyGo))
    else $error("completion pulse out of step");

  // Dropping the erase enable leaves the page buffer empty
  buffer_clear_a: assert property ( // [R9]
    $fell(st_q.ctl.wipeAllow) |-> (st_q.pageBuf == '0) && (st_q.tags == '0))
    else $error("page buffer kept after erase enable fell");

  // Leaving reset shows the data and control reset values
  reset_value_a: assert property ( // [R1]
    $rose(rst_n) |-> (st_q.data == DATA_RESET) &&
      (st_q.ctl == nvde_ctrl_t'(CTRL_RESET)))
    else $error("registers not at reset values");

endmodule : nvde_control

/* test/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  import nvde_pkg::*;

  // ---------------------------------------------
  // Signals and counters
  // ---------------------------------------------
  logic          ref_clk;    // System clock
  logic          rst_n;      // Sync reset, low
  nvde_sfr_req_t sfrReq;     // Register write
  logic [1:0]    sfrRdSel;   // Read select
  logic [7:0]    sfrRdData;  // Read data
  logic          cycleDone;  // End pulse
  int            error_cnt;  // Mismatches
  int            compares;   // Comparisons
  int            cycCnt;     // Watchdog count
  logic [31:0]   rnd;        // Random state
  logic [7:0]    expPage [16]; // Page image

  // Short counts keep the run brief
  localparam int N_WS = 20, N_SS = 12, N_WL = 30, N_SL = 25;

  nvde_control #(
    .WIPE_SHORT_CYC (19'(N_WS)),
    .STORE_SHORT_CYC(19'(N_SS)),
    .WIPE_LONG_CYC  (19'(N_WL)),
    .STORE_LONG_CYC (19'(N_SL))
  ) u_nvde_control (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .sfrReq   (sfrReq),
    .sfrRdSel (sfrRdSel),
    .sfrRdData(sfrRdData),
    .cycleDone(cycleDone)
  );

  // ---------------------------------------------
  // Clock, watchdog and helpers
  // ---------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Cut a hang short
  always @(posedge ref_clk) begin
    cycCnt <= cycCnt + 1;
    if (cycCnt == 5000) begin
      error_cnt++;
      test_done();
    end
  end

  // Next random value
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Busy length that an erase or write should show
  function automatic int exp_cycles(input logic isWipe,
                                    input logic longSel);
    if (isWipe) begin
      return longSel ? N_WL : N_WS;
    end
    return longSel ? N_SL : N_SS;
  endfunction : exp_cycles

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One register write, one cycle strobe
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    @(negedge ref_clk);
    sfrReq = '{1'b1, s, d};
    @(negedge ref_clk);
    sfrReq.write = 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] s, output logic [7:0] v);
    sfrRdSel = s;
    #1 v = sfrRdData;
  endtask : rd

  // Arm, launch, count busy cycles, check the end
  task automatic cyc(input logic [7:0] go, input logic [7:0] m,
                     input logic [7:0] am, input int n);
    int k;
    logic [7:0] v;
    k = 0;
    wr(SEL_CONTROL, go & ~m);
    wr(SEL_CONTROL, go);
    rd(SEL_CONTROL, v);
    while ((v & m) != 8'h00 && k < 1000) begin
      k++;
      @(negedge ref_clk);
      rd(SEL_CONTROL, v);
    end
    chk(8'(k), 8'(n));
    chk({7'h00, cycleDone}, 8'h01);
    chk(v & am, 8'h00);
  endtask : cyc

  // Start a read and fetch the data byte
  task automatic fetch(input logic [7:0] c, output logic [7:0] v);
    int k;
    wr(SEL_CONTROL, c);
    k = 0;
    rd(SEL_CONTROL, v);
    while (v[0] !== 1'b0 && k < 8) begin
      k++;
      @(negedge ref_clk);
      rd(SEL_CONTROL, v);
    end
    chk({7'h00, v[0]}, 8'h00);
    rd(SEL_DATA, v);
  endtask : fetch

  task automatic test_done();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    logic [7:0] v, d;
    logic [7:0] refuse [3];
    error_cnt = 0;
    compares = 0;
    cycCnt = 0;
    rnd = 32'd70043;
    rst_n = 1'b0;
    sfrReq = '0;
    sfrRdSel = SEL_DATA;
    refuse = '{8'h20, 8'h04, 8'h01};
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    // Reset values and register access
    for (int s = 0; s < 4; s++) begin
      rd(2'(s), v);
      chk(v, 8'h00);
    end
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      wr(SEL_DATA, rnd[7:0]);
      rd(SEL_DATA, v);
      chk(v, rnd[7:0]);
    end
    wr(SEL_ADDR_HIGH, 8'hff);
    rd(SEL_ADDR_HIGH, v);
    chk(v, 8'h07);
    $display("registers done");
    // Go bits without their enable are ignored
    foreach (refuse[i]) begin
      wr(SEL_CONTROL, refuse[i]);
      rd(SEL_CONTROL, v);
      chk(v, 8'h00);
      chk({7'h00, cycleDone}, 8'h00);
    end
    $display("refusal done");
    // Byte store, read back, erase, both timings
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      d = rnd[23:16];
      wr(SEL_ADDR_LOW, rnd[7:0]);
      wr(SEL_ADDR_HIGH, {5'h00, rnd[10:8]});
      wr(SEL_DATA, d);
      cyc({i[0], 7'h0c}, 8'h04, 8'h08, exp_cycles(1'b0, i[0]));
      wr(SEL_DATA, ~d);
      wr(SEL_CONTROL, 8'h02);
      fetch(8'h03, v);
      chk(v, d);
      cyc({i[0], 7'h60}, 8'h20, 8'h40, exp_cycles(1'b1, i[0]));
      wr(SEL_CONTROL, 8'h02);
      fetch(8'h03, v);
      chk(v, 8'h00);
    end
    $display("byte cycles done");
    // Page store of sixteen bytes, page read, page erase
    wr(SEL_CONTROL, 8'h10);
    wr(SEL_ADDR_HIGH, 8'h05);
    wr(SEL_ADDR_LOW, 8'h20);
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      expPage[i] = rnd[7:0];
      wr(SEL_DATA, rnd[7:0]);
    end
    rd(SEL_ADDR_LOW, v);
    chk(v, 8'h2f);
    cyc(8'h1c, 8'h04, 8'h08, exp_cycles(1'b0, 1'b0));
    wr(SEL_ADDR_LOW, 8'h20);
    wr(SEL_CONTROL, 8'h12);
    for (int i = 0; i < 17; i++) begin
      fetch(8'h13, v);
      chk(v, expPage[i > 15 ? 15 : i]);
    end
    wr(SEL_ADDR_LOW, 8'h23);
    wr(SEL_DATA, 8'h5a);
    cyc(8'h70, 8'h20, 8'h40, exp_cycles(1'b1, 1'b0));
    wr(SEL_ADDR_LOW, 8'h23);
    wr(SEL_CONTROL, 8'h12);
    fetch(8'h13, v);
    chk(v, 8'h00);
    fetch(8'h13, v);
    chk(v, expPage[4]);
    $display("page cycles done");
    // Reset in mid-run brings data and control back to their reset values
    wr(SEL_DATA, 8'ha5);
    @(negedge ref_clk);
    rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    rd(SEL_DATA, v);
    chk(v, DATA_RESET);
    rd(SEL_CONTROL, v);
    chk(v, CTRL_RESET);
    $display("reset done");
    test_done();
  end
endmodule : tb_top
